/* dcod_pkg.sv */
package dcod_pkg;

  // Decoded operation classes
  typedef enum logic [4:0] {
    OP_NONE,
    OP_BRANCH_COND,
    OP_TEST_FLAG_INDEXED,
    OP_DATA_BLOCK_MOVE_SRC,
    OP_DATA_BLOCK_MOVE_DST,
    OP_PROG_TO_DATA_BLOCK_MOVE,
    OP_CONFIG_BLOCK_DATA,
    OP_AUX_COMPARE,
    OP_DATA_SHIFT_MOVE,
    OP_PORT_INPUT,
    OP_LOAD_SUM_LONG,
    OP_LOAD_SUM_SHIFTED,
    OP_LOAD_SUM_HIGH,
    OP_LOAD_SUM_SHORT,
    OP_LOAD_SUM_LOW,
    OP_LOAD_SUM_VARIABLE_SHIFT,
    OP_LOAD_AUX_DIRECT,
    OP_LOAD_AUX_SHORT,
    OP_LOAD_AUX_LONG,
    OP_LOAD_PAGE_IMM,
    OP_LOAD_PAGE_DIRECT,
    OP_LOAD_STATUS_ZERO,
    OP_LOAD_STATUS_ONE,
    OP_LOAD_OPERAND_ADD_PRODUCT,
    OP_LOAD_OPERAND_ADD_MOVE
  } dcod_op_t;

  // Decoder states: first word or awaiting second word
  typedef enum logic {
    ST_FIRST,
    ST_SECOND
  } dcod_state_t;

  // Condition selector field values
  localparam logic [1:0] COND_PIN_LOW   = 2'h0;
  localparam logic [1:0] COND_FLAG_SET  = 2'h1;
  localparam logic [1:0] COND_FLAG_CLR  = 2'h2;
  localparam logic [1:0] COND_NONE      = 2'h3;

  // Word and cycle counts
  localparam logic [1:0] WORDS_ONE       = 2'h1;
  localparam logic [1:0] WORDS_TWO       = 2'h2;
  localparam logic [2:0] CYC_ONE         = 3'h1;
  localparam logic [2:0] CYC_TWO         = 3'h2;
  localparam logic [2:0] CYC_THREE       = 3'h3;
  localparam logic [2:0] CYC_BRANCH_TAKE = 3'h4;
  localparam logic [2:0] CYC_BRANCH_SKIP = 3'h2;

  // Reset values
  localparam logic [15:0] RESET_WORD = 16'h0000;

endpackage

/* dcod_decoder.sv */
`timescale 1ns/100ps
// Functional notes
// RULE1: Branch if nonzero, branch on overflow
// RULE2: Branch if accumulator zero, two words
// RULE3: Bit test indexed by operand register
// RULE4: Block move, source address immediate
// RULE5: Block move, destination address immediate
// RULE6: Program-to-data block move, three cycles
// RULE7: Source-immediate move unsafe on interrupt registers
// RULE8: Configure dual-access block as data
// RULE9: Compare current aux with aux zero
// RULE10: Move data word to next address
// RULE11: Port input, port in second word
// RULE12: Long immediate sum load with shift
// RULE13: Sum load from memory with shift
// RULE14: Load high half, clear low
// RULE15: Short immediate sum load, zero allowed
// RULE16: Load low half, no sign extension
// RULE17: Sum load shifted by operand register
// RULE18: Aux register direct, short, long loads
// RULE19: Page pointer immediate and direct loads
// RULE20: Status register zero and one loads
// RULE21: Load operand, add previous product
// RULE22: Load operand, add product, move data
// RULE23: Condition mask, states and selector field
// RULE24: Second word fetched next, never decoded
module dcod_decoder (
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              word_valid_in,
  input  wire logic [15:0]       word_in,
  output dcod_pkg::dcod_op_t     op_out,
  output logic                   op_valid_out,
  output logic                   second_word_out,
  output logic [15:0]            operand_word_out,
  output logic [7:0]             addr_field_out,
  output logic [3:0]             shift_count_out,
  output logic [2:0]             aux_register_select_out,
  output logic [1:0]             compare_condition_select_out,
  output logic [8:0]             page_imm_out,
  output logic [3:0]             condition_mask_out,
  output logic [3:0]             condition_flags_field_out,
  output logic [1:0]             pin_or_flag_condition_out,
  output logic [1:0]             words_out,
  output logic [2:0]             cycles_taken_out,
  output logic [2:0]             cycles_skip_out,
  output logic                   protected_reg_hazard_out
);
  import dcod_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of a first word into operation, size and cost
  typedef struct packed {
    dcod_op_t   op;
    logic [1:0] words;
    logic [2:0] taken;
    logic [2:0] skip;
  } dcod_dec_t;

  function automatic dcod_dec_t dcod_decode(input logic [15:0] w);
    dcod_dec_t d;
    d = '{OP_NONE, WORDS_ONE, CYC_ONE, CYC_ONE};
    if (w == 16'he308 || w == 16'he322) begin
      d = '{OP_BRANCH_COND, WORDS_TWO, CYC_BRANCH_TAKE, CYC_BRANCH_SKIP}; // [RULE1]
    end else if (w == 16'he388) begin
      d = '{OP_BRANCH_COND, WORDS_TWO, CYC_BRANCH_TAKE, CYC_BRANCH_SKIP}; // [RULE2]
    end else if (w == 16'hbe44) begin
      d = '{OP_CONFIG_BLOCK_DATA, WORDS_ONE, CYC_ONE, CYC_ONE};           // [RULE8]
    end else if (w[15:2] == 14'h2fd1) begin
      d = '{OP_AUX_COMPARE, WORDS_ONE, CYC_ONE, CYC_ONE};                 // [RULE9]
    end else if (w[15:4] == 12'hbf8) begin
      d = '{OP_LOAD_SUM_LONG, WORDS_TWO, CYC_TWO, CYC_TWO};               // [RULE12]
    end else if (w[15:3] == 13'h17e1) begin
      d = '{OP_LOAD_AUX_LONG, WORDS_TWO, CYC_TWO, CYC_TWO};               // [RULE18]
    end else if (w[15:9] == 7'h5e) begin
      d = '{OP_LOAD_PAGE_IMM, WORDS_ONE, CYC_TWO, CYC_TWO};               // [RULE19]
    end else if (w[15:12] == 4'h1) begin
      d = '{OP_LOAD_SUM_SHIFTED, WORDS_ONE, CYC_ONE, CYC_ONE};            // [RULE13]
    end else if (w[15:11] == 5'h00) begin
      d = '{OP_LOAD_AUX_DIRECT, WORDS_ONE, CYC_TWO, CYC_TWO};             // [RULE18]
    end else if (w[15:11] == 5'h16) begin
      d = '{OP_LOAD_AUX_SHORT, WORDS_ONE, CYC_TWO, CYC_TWO};              // [RULE18]
    end else begin
      unique case (w[15:8])
        8'h6f: d = '{OP_TEST_FLAG_INDEXED, WORDS_ONE, CYC_ONE, CYC_ONE};        // [RULE3]
        8'ha8: d = '{OP_DATA_BLOCK_MOVE_SRC, WORDS_TWO, CYC_THREE, CYC_THREE};  // [RULE4]
        8'ha9: d = '{OP_DATA_BLOCK_MOVE_DST, WORDS_TWO, CYC_THREE, CYC_THREE};  // [RULE5]
        8'ha5: d = '{OP_PROG_TO_DATA_BLOCK_MOVE, WORDS_TWO, CYC_THREE, CYC_THREE}; // [RULE6]
        8'h77: d = '{OP_DATA_SHIFT_MOVE, WORDS_ONE, CYC_ONE, CYC_ONE};          // [RULE10]
        8'haf: d = '{OP_PORT_INPUT, WORDS_TWO, CYC_TWO, CYC_TWO};               // [RULE11]
        8'h6a: d = '{OP_LOAD_SUM_HIGH, WORDS_ONE, CYC_ONE, CYC_ONE};            // [RULE14]
        8'hb9: d = '{OP_LOAD_SUM_SHORT, WORDS_ONE, CYC_ONE, CYC_ONE};           // [RULE15]
        8'h69: d = '{OP_LOAD_SUM_LOW, WORDS_ONE, CYC_ONE, CYC_ONE};             // [RULE16]
        8'h6b: d = '{OP_LOAD_SUM_VARIABLE_SHIFT, WORDS_ONE, CYC_ONE, CYC_ONE};  // [RULE17]
        8'h0d: d = '{OP_LOAD_PAGE_DIRECT, WORDS_ONE, CYC_TWO, CYC_TWO};         // [RULE19]
        8'h0e: d = '{OP_LOAD_STATUS_ZERO, WORDS_ONE, CYC_TWO, CYC_TWO};         // [RULE20]
        8'h0f: d = '{OP_LOAD_STATUS_ONE, WORDS_ONE, CYC_TWO, CYC_TWO};          // [RULE20]
        8'h70: d = '{OP_LOAD_OPERAND_ADD_PRODUCT, WORDS_ONE, CYC_ONE, CYC_ONE}; // [RULE21]
        8'h72: d = '{OP_LOAD_OPERAND_ADD_MOVE, WORDS_ONE, CYC_ONE, CYC_ONE};    // [RULE22]
        default: d = '{OP_NONE, WORDS_ONE, CYC_ONE, CYC_ONE};
      endcase
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Whole module state
  typedef struct packed {
    dcod_state_t state;
    dcod_op_t    op;
    logic        op_valid;
    logic        second;
    logic [15:0] first;
    logic [15:0] operand;
    logic [1:0]  words;
    logic [2:0]  taken;
    logic [2:0]  skip;
  } dcod_regs_t;

  dcod_regs_t r;
  dcod_regs_t next_r;
  dcod_dec_t  dec;

  // First-word decode and sequencing of the second word
  always_comb begin
    dec = dcod_decode(word_in);
    next_r = r;
    next_r.op_valid = 1'b0;
    next_r.second = 1'b0;
    if (word_valid_in) begin
      unique case (r.state)
        ST_FIRST: begin
          next_r.first = word_in;
          next_r.op = dec.op;
          next_r.words = dec.words;
          next_r.taken = dec.taken;
          next_r.skip = dec.skip;
          next_r.operand = RESET_WORD;
          if (dec.words == WORDS_TWO) begin
            next_r.state = ST_SECOND;                   // [RULE24]
          end else begin
            next_r.op_valid = 1'b1;
          end
        end
        ST_SECOND: begin
          next_r.operand = word_in;                     // [RULE24]
          next_r.second = 1'b1;
          next_r.op_valid = 1'b1;
          next_r.state = ST_FIRST;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      r <= '{ST_FIRST, OP_NONE, 1'b0, 1'b0, RESET_WORD, RESET_WORD, WORDS_ONE, CYC_ONE, CYC_ONE};
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from the held state; fields taken from the held first word, operand from the second
  assign op_out = r.op;
  assign op_valid_out = r.op_valid;
  assign second_word_out = r.second;
  assign operand_word_out = r.operand;
  assign addr_field_out = r.first[7:0];
  assign shift_count_out = (r.op == OP_LOAD_SUM_SHIFTED) ? r.first[11:8] : r.first[3:0]; // [RULE12] [RULE13]
  assign aux_register_select_out = (r.op == OP_LOAD_AUX_DIRECT || r.op == OP_LOAD_AUX_SHORT) ?
                                   r.first[10:8] : r.first[2:0];                       // [RULE18]
  assign compare_condition_select_out = r.first[1:0];                                  // [RULE9]
  assign page_imm_out = r.first[8:0];                                                  // [RULE19]
  // Condition fields of conditional forms
  assign condition_mask_out = r.first[3:0];                                            // [RULE23]
  assign condition_flags_field_out = r.first[7:4];                                     // [RULE23]
  assign pin_or_flag_condition_out = (r.op == OP_BRANCH_COND) ? COND_NONE : r.first[9:8]; // [RULE23]
  assign words_out = r.words;
  assign cycles_taken_out = r.taken;
  assign cycles_skip_out = r.skip;
  // Flags a source-immediate block move which software must keep off interrupt registers
  assign protected_reg_hazard_out = r.op_valid && (r.op == OP_DATA_BLOCK_MOVE_SRC);    // [RULE7]

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence seq_two_word_first;
    word_valid_in && r.state == ST_FIRST && dec.words == WORDS_TWO;
  endsequence

  // First word taken whose cared-for bits match a given pattern
  sequence seq_first_masked(logic [15:0] code, logic [15:0] care);
    word_valid_in && r.state == ST_FIRST && (word_in & care) == code;
  endsequence

  AST_TWO_WORD_WAITS: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE24]
    seq_two_word_first |=> r.state == ST_SECOND && !op_valid_out)
    else $error("two-word opcode not held for second word");

  AST_SECOND_NOT_OPCODE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE24]
    (seq_two_word_first ##1 word_valid_in) |=> op_valid_out && second_word_out && operand_word_out == $past(word_in))
    else $error("second word decoded as opcode");

  AST_BRANCH_COST: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE1]
    (word_valid_in && r.state == ST_FIRST && word_in == 16'he308) |=>
      op_out == OP_BRANCH_COND && cycles_taken_out == 3'h4 && cycles_skip_out == 3'h2)
    else $error("branch cost wrong");

  AST_BRANCH_ZERO: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE2]
    (word_valid_in && r.state == ST_FIRST && word_in == 16'he388) |=> words_out == 2'h2)
    else $error("branch on zero not two words");

  AST_PROG_MOVE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE6]
    (word_valid_in && r.state == ST_FIRST && word_in[15:8] == 8'ha5) |=> cycles_taken_out == 3'h3)
    else $error("program move cost wrong");

  AST_SHORT_LOAD: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE15]
    (word_valid_in && r.state == ST_FIRST && word_in[15:8] == 8'hb9) |=>
      op_valid_out && op_out == OP_LOAD_SUM_SHORT && addr_field_out == $past(word_in[7:0]))
    else $error("short load not decoded");

  AST_SHIFT_FIELD: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE13]
    (word_valid_in && r.state == ST_FIRST && word_in[15:12] == 4'h1) |=> shift_count_out == $past(word_in[11:8]))
    else $error("shift count wrong");

  AST_STATUS_COST: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE20]
    (word_valid_in && r.state == ST_FIRST && word_in[15:9] == 7'h07) |=> cycles_taken_out == 3'h2 && words_out == 2'h1)
    else $error("status load cost wrong");

  AST_HAZARD: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE7]
    protected_reg_hazard_out |-> op_out == OP_DATA_BLOCK_MOVE_SRC && second_word_out)
    else $error("hazard flag without block move");

  AST_BIT_TEST: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE3]
    seq_first_masked(16'h6f00, 16'hff00) |=> op_valid_out && op_out == OP_TEST_FLAG_INDEXED)
    else $error("indexed bit test not decoded");

  AST_MOVE_SRC: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE4]
    seq_first_masked(16'ha800, 16'hff00) |=>
      op_out == OP_DATA_BLOCK_MOVE_SRC && words_out == WORDS_TWO && addr_field_out == $past(word_in[7:0]))
    else $error("source-immediate move not decoded");

  AST_MOVE_DST: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE5]
    seq_first_masked(16'ha900, 16'hff00) |=>
      op_out == OP_DATA_BLOCK_MOVE_DST && words_out == WORDS_TWO && cycles_taken_out == CYC_THREE)
    else $error("destination-immediate move not decoded");

  AST_HAZARD_PULSE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE7]
    (seq_first_masked(16'ha800, 16'hff00) ##1 word_valid_in) |=> protected_reg_hazard_out && op_valid_out)
    else $error("hazard flag missing on source-immediate move");

  AST_CONFIG_DATA: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE8]
    seq_first_masked(16'hbe44, 16'hffff) |=> op_valid_out && op_out == OP_CONFIG_BLOCK_DATA)
    else $error("block configure not decoded");

  AST_AUX_COMPARE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE9]
    seq_first_masked(16'hbf44, 16'hfffc) |=>
      op_out == OP_AUX_COMPARE && compare_condition_select_out == $past(word_in[1:0]))
    else $error("aux compare not decoded");

  AST_DATA_SHIFT_MOVE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE10]
    seq_first_masked(16'h7700, 16'hff00) |=> op_valid_out && op_out == OP_DATA_SHIFT_MOVE)
    else $error("data move not decoded");

  AST_PORT_INPUT: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE11]
    seq_first_masked(16'haf00, 16'hff00) |=>
      op_out == OP_PORT_INPUT && words_out == WORDS_TWO && cycles_taken_out == CYC_TWO)
    else $error("port input not decoded");

  AST_LONG_SUM: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE12]
    seq_first_masked(16'hbf80, 16'hfff0) |=>
      op_out == OP_LOAD_SUM_LONG && words_out == WORDS_TWO && shift_count_out == $past(word_in[3:0]))
    else $error("long sum load not decoded");

  AST_LOAD_HIGH: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE14]
    seq_first_masked(16'h6a00, 16'hff00) |=> op_valid_out && op_out == OP_LOAD_SUM_HIGH)
    else $error("high half load not decoded");

  AST_LOAD_LOW: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE16]
    seq_first_masked(16'h6900, 16'hff00) |=> op_valid_out && op_out == OP_LOAD_SUM_LOW)
    else $error("low half load not decoded");

  AST_VAR_SHIFT: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE17]
    seq_first_masked(16'h6b00, 16'hff00) |=> op_valid_out && op_out == OP_LOAD_SUM_VARIABLE_SHIFT)
    else $error("operand-shifted load not decoded");

  AST_AUX_DIRECT: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE18]
    seq_first_masked(16'h0000, 16'hf800) |=>
      op_out == OP_LOAD_AUX_DIRECT && cycles_taken_out == CYC_TWO && aux_register_select_out == $past(word_in[10:8]))
    else $error("direct aux load not decoded");

  AST_AUX_LONG: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE18]
    seq_first_masked(16'hbf08, 16'hfff8) |=>
      op_out == OP_LOAD_AUX_LONG && words_out == WORDS_TWO && aux_register_select_out == $past(word_in[2:0]))
    else $error("long aux load not decoded");

  AST_PAGE_IMM: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE19]
    seq_first_masked(16'hbc00, 16'hfe00) |=>
      op_out == OP_LOAD_PAGE_IMM && cycles_taken_out == CYC_TWO && page_imm_out == $past(word_in[8:0]))
    else $error("page pointer load not decoded");

  AST_OPERAND_ADD: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE21]
    seq_first_masked(16'h7000, 16'hff00) |=> op_valid_out && op_out == OP_LOAD_OPERAND_ADD_PRODUCT)
    else $error("operand load with add not decoded");

  AST_OPERAND_MOVE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE22]
    seq_first_masked(16'h7200, 16'hff00) |=> op_valid_out && op_out == OP_LOAD_OPERAND_ADD_MOVE)
    else $error("operand load with move not decoded");

  AST_COND_FIELDS: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RULE23]
    seq_first_masked(16'he308, 16'hffff) |=> condition_mask_out == 4'h8 && condition_flags_field_out == 4'h0 &&
      pin_or_flag_condition_out == COND_NONE)
    else $error("condition fields wrong");

endmodule

/* dcod_fetch_model.sv */
`timescale 1ns/100ps
module dcod_fetch_model (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  output logic             word_valid_out,
  output logic [15:0]      word_out
);
  logic [15:0] q_word [$];
  int          q_gap [$];
  int          wait_cnt = 0;
  logic [15:0] last_word = 16'h0000;

  // Bus idle before the first clock edge
  initial begin
    word_valid_out = 1'b0;
    word_out       = 16'hffff;
  end

  // Queue a word; gap stalls the fetch for that many cycles first
  task automatic push(input logic [15:0] w, input int gap);
    q_word.push_back(w);
    q_gap.push_back(gap);
  endtask

  ////////////////////////////////////////////////////////////////
  // Hand out words in order; idle bus shows the inverse of the last word
  always @(posedge clk_in) begin
    if (!reset_n_in || q_word.size() == 0 || wait_cnt < q_gap[0]) begin
      word_valid_out <= 1'b0;
      word_out       <= ~last_word;
      if (reset_n_in && q_word.size() != 0) begin
        wait_cnt <= wait_cnt + 1;
      end
    end else begin
      word_valid_out <= 1'b1; // Operand word follows its opcode in order
      word_out       <= q_word[0];
      last_word      <= q_word[0];
      wait_cnt       <= 0;
      void'(q_word.pop_front());
      void'(q_gap.pop_front());
    end
  end
endmodule

/* dcod_decoder_tb.sv */
`timescale 1ns/100ps
module dcod_decoder_tb;
  import dcod_pkg::*;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        word_valid, op_valid, second_word, hazard, hz;
  logic [15:0] word, operand_word;
  dcod_op_t    op;
  logic [7:0]  addr;
  logic [3:0]  shift, mask, flags;
  logic [2:0]  aux, cyc_t, cyc_s;
  logic [1:0]  cmp, pin, words;
  logic [8:0]  page;
  int          errors = 0;
  int          n_checks = 0;

  always #5 clk_in = ~clk_in;

  dcod_fetch_model fetch_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .word_valid_out(word_valid), .word_out(word));

  dcod_decoder dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .word_valid_in(word_valid), .word_in(word),
    .op_out(op), .op_valid_out(op_valid), .second_word_out(second_word), .operand_word_out(operand_word),
    .addr_field_out(addr), .shift_count_out(shift), .aux_register_select_out(aux),
    .compare_condition_select_out(cmp), .page_imm_out(page), .condition_mask_out(mask),
    .condition_flags_field_out(flags), .pin_or_flag_condition_out(pin), .words_out(words),
    .cycles_taken_out(cyc_t), .cycles_skip_out(cyc_s), .protected_reg_hazard_out(hazard));

  ////////////////////////////////////////////////////////////////
  // Verdict and comparisons
  task automatic end_of_test();
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic chk_op(input dcod_op_t exp, input dcod_op_t got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Wait for the decode pulse, then judge class, counts and operand
  task automatic expect_op(input dcod_op_t e_op, input logic [1:0] w, input logic [2:0] cyc, input logic [15:0] opnd);
    int i;
    for (i = 0; i < 30 && op_valid !== 1'b1; i++) @(negedge clk_in);
    if (op_valid !== 1'b1) begin
      errors++;
      end_of_test();
    end else begin
      hz = hazard;
      chk_op(e_op, op);
      chk_val({14'h0, w}, {14'h0, words});
      if (cyc !== 3'h0) chk_val({13'h0, cyc}, {13'h0, cyc_t});
      chk_val((w == WORDS_TWO) ? opnd : 16'h0000, operand_word);
      chk_val({15'h0, w == WORDS_TWO}, {15'h0, second_word});
      @(negedge clk_in);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic sc_branches();
    logic [15:0] code [3] = '{16'he308, 16'he322, 16'he388};
    for (int k = 0; k < 3; k++) begin
      fetch_u.push(code[k], 0);
      fetch_u.push(16'h4000 + 16'(k), 0);
      expect_op(OP_BRANCH_COND, WORDS_TWO, CYC_BRANCH_TAKE, 16'h4000 + 16'(k));
      chk_val({13'h0, CYC_BRANCH_SKIP}, {13'h0, cyc_s});
      chk_val({8'h0, code[k][7:0]}, {8'h0, flags, mask});
      chk_val({14'h0, COND_NONE}, {14'h0, pin});
    end
  endtask

  // Two-word moves, port input and long sum load sent back to back
  task automatic sc_moves();
    fetch_u.push(16'ha834, 0); fetch_u.push(16'h1234, 0); fetch_u.push(16'ha956, 0); fetch_u.push(16'h0300, 0);
    fetch_u.push(16'ha577, 0); fetch_u.push(16'h0f00, 0); fetch_u.push(16'haf10, 0); fetch_u.push(16'hffee, 0);
    fetch_u.push(16'hbf83, 0); fetch_u.push(16'h0042, 0);
    expect_op(OP_DATA_BLOCK_MOVE_SRC, WORDS_TWO, 3'h0, 16'h1234);
    chk_val(16'h0001, {15'h0, hz});
    expect_op(OP_DATA_BLOCK_MOVE_DST, WORDS_TWO, CYC_THREE, 16'h0300);
    chk_val(16'h0000, {15'h0, hz});
    expect_op(OP_PROG_TO_DATA_BLOCK_MOVE, WORDS_TWO, CYC_THREE, 16'h0f00);
    expect_op(OP_PORT_INPUT, WORDS_TWO, CYC_TWO, 16'hffee);
    expect_op(OP_LOAD_SUM_LONG, WORDS_TWO, CYC_TWO, 16'h0042);
    chk_val(16'h0003, {12'h0, shift});
  endtask

  // One-word opcodes streamed back to back
  task automatic sc_one_word();
    logic [15:0] code [18] = '{16'hbe44, 16'hbf45, 16'h7712, 16'h6f12, 16'h1a56, 16'h6a20, 16'hb900, 16'h6921,
      16'h6b22, 16'h0512, 16'hb3ff, 16'hbd23, 16'h0d40, 16'h0e41, 16'h0f42, 16'h7043, 16'h7244, 16'h8b00};
    dcod_op_t    e_op [18] = '{OP_CONFIG_BLOCK_DATA, OP_AUX_COMPARE, OP_DATA_SHIFT_MOVE, OP_TEST_FLAG_INDEXED,
      OP_LOAD_SUM_SHIFTED, OP_LOAD_SUM_HIGH, OP_LOAD_SUM_SHORT, OP_LOAD_SUM_LOW, OP_LOAD_SUM_VARIABLE_SHIFT,
      OP_LOAD_AUX_DIRECT, OP_LOAD_AUX_SHORT, OP_LOAD_PAGE_IMM, OP_LOAD_PAGE_DIRECT, OP_LOAD_STATUS_ZERO,
      OP_LOAD_STATUS_ONE, OP_LOAD_OPERAND_ADD_PRODUCT, OP_LOAD_OPERAND_ADD_MOVE, OP_NONE};
    logic [2:0]  e_cyc [18] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h0, 3'h2, 3'h2,
      3'h2, 3'h2, 3'h1, 3'h1, 3'h1};
    for (int k = 0; k < 18; k++) fetch_u.push(code[k], 0);
    for (int k = 0; k < 18; k++) begin
      expect_op(e_op[k], WORDS_ONE, e_cyc[k], 16'h0000);
    end // Same loop also
  endtask

  // Operand fields held after decode
  task automatic sc_fields();
    fetch_u.push(16'h1a56, 0);
    expect_op(OP_LOAD_SUM_SHIFTED, WORDS_ONE, CYC_ONE, 16'h0000);
    chk_val(16'h0a56, {4'h0, shift, addr});
    fetch_u.push(16'hbf46, 0);
    expect_op(OP_AUX_COMPARE, WORDS_ONE, CYC_ONE, 16'h0000);
    chk_val(16'h0002, {14'h0, cmp});
    fetch_u.push(16'h0512, 0);
    expect_op(OP_LOAD_AUX_DIRECT, WORDS_ONE, CYC_TWO, 16'h0000);
    chk_val(16'h0005, {13'h0, aux});
    fetch_u.push(16'hbf0e, 0);
    fetch_u.push(16'hbeef, 0);
    expect_op(OP_LOAD_AUX_LONG, WORDS_TWO, CYC_TWO, 16'hbeef);
    chk_val(16'h0006, {13'h0, aux});
    fetch_u.push(16'hbd23, 0);
    expect_op(OP_LOAD_PAGE_IMM, WORDS_ONE, CYC_TWO, 16'h0000);
    chk_val(16'h0123, {7'h0, page});
  endtask

  // Stalled operand that looks like an opcode, then a one-word op
  task automatic sc_gap();
    fetch_u.push(16'he388, 0);
    fetch_u.push(16'h6f12, 3);
    fetch_u.push(16'h6a01, 0);
    expect_op(OP_BRANCH_COND, WORDS_TWO, CYC_BRANCH_TAKE, 16'h6f12);
    expect_op(OP_LOAD_SUM_HIGH, WORDS_ONE, CYC_ONE, 16'h0000);
  endtask

  // Reset while an operand is still awaited drops the half-taken branch
  task automatic sc_reset();
    fetch_u.push(16'he308, 0);
    repeat (2) @(negedge clk_in);
    @(posedge clk_in) reset_n_in <= 1'b0;
    repeat (2) @(negedge clk_in);
    chk_op(OP_NONE, op);
    chk_val(16'h0001, {14'h0, words});
    @(posedge clk_in) reset_n_in <= 1'b1;
    @(negedge clk_in);
    fetch_u.push(16'h6f12, 0);
    expect_op(OP_TEST_FLAG_INDEXED, WORDS_ONE, CYC_ONE, 16'h0000);
  endtask

  initial begin
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(negedge clk_in);
    sc_branches();
    sc_moves();
    sc_one_word();
    sc_fields();
    sc_gap();
    sc_reset();
    end_of_test();
  end
endmodule
